// *** verilog/svm_pkg.sv ***
// Contract
// - program in nonvolatile store, data in ram
// - ram-only words at V1400-V7377, V10000-V17777
// - V7400-V7777 is the flash-backed area
// - retentive ranges survive power cycle and run
// - non-retentive ranges cleared on power and run
// - flash written only by move or tool
// - accepted flash write also updates ram
// - other instruction writes update ram only
// - nonvolatile reads always return the ram copy
// - power-up copies whole flash area into ram
package svm_pkg;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 16;
    localparam int PROG_AW = 10;
    localparam int NV_AW = 8;
    localparam logic [12:0] RAM_LO_FIRST = 13'h0300;
    localparam logic [12:0] RAM_LO_LAST = 13'h0eff;
    localparam logic [12:0] NV_FIRST = 13'h0f00;
    localparam logic [12:0] NV_LAST = 13'h0fff;
    localparam logic [12:0] RAM_HI_FIRST = 13'h1000;
    localparam logic [12:0] RAM_HI_LAST = 13'h1fff;
    localparam logic [12:0] SWEEP_LAST = 13'h1fff;
    localparam logic [15:0] CLEAR_VALUE = 16'h0000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int FLASH_WR_NS = 1000;
    localparam int FLASH_WR_CYC = (FLASH_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_W = 8;
    localparam logic [7:0] FLASH_WR_COUNT = 8'(FLASH_WR_CYC);
    typedef enum logic [1:0] {
        SRC_OTHER_INSTR,
        SRC_MOVE,
        SRC_TOOL,
        SRC_RESERVED
    } svm_src_e;
    typedef enum logic [1:0] {
        ST_SWEEP,
        ST_IDLE,
        ST_FLASH_BUSY
    } svm_state_e;
endpackage

// *** verilog/svm_top.sv ***
// inclusive at both ends, so a one-word range is legal
module svm_range_chk
#(
    parameter int W = 13
)
(
    input wire logic [W-1:0] addr_in,
    input wire logic [W-1:0] first_in,
    input wire logic [W-1:0] last_in,
    output logic hit_out
);
    assign hit_out = (addr_in >= first_in) && (addr_in <= last_in);
endmodule

module svm_top
    import svm_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic run_mode_in,
    input wire logic ret_en_in,
    input wire logic [12:0] ret_first_in,
    input wire logic [12:0] ret_last_in,
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [1:0] req_src_in,
    input wire logic [12:0] req_addr_in,
    input wire logic [15:0] req_wdata_in,
    output logic req_ready_out,
    output logic rsp_valid_out,
    output logic [15:0] rsp_rdata_out,
    output logic rsp_err_out,
    output logic rsp_flash_out,
    output logic flash_busy_out,
    output logic sweep_busy_out,
    input wire logic prog_wr_in,
    input wire logic prog_rd_in,
    input wire logic [9:0] prog_addr_in,
    input wire logic [15:0] prog_wdata_in,
    output logic prog_rvalid_out,
    output logic [15:0] prog_rdata_out
);

    // memories carry no reset: their contents model backed storage
    logic [15:0] ram_mem [0:8191];
    logic [15:0] flash_mem [0:255];
    logic [15:0] prog_mem [0:1023];

    svm_state_e state_q;
    svm_state_e state_d;
    logic [12:0] sweep_addr_q;
    logic [12:0] sweep_addr_d;
    logic power_up_q;
    logic power_up_d;
    logic run_q;
    logic [7:0] busy_cnt_q;
    logic [7:0] busy_cnt_d;
    logic rsp_valid_q;
    logic [15:0] rsp_rdata_q;
    logic rsp_err_q;
    logic rsp_flash_q;
    logic prog_rvalid_q;
    logic [15:0] prog_rdata_q;

    // request address decode
    wire req_in_ram_lo;
    wire req_in_nv;
    wire req_in_ram_hi;
    wire req_mapped;
    wire flash_src_ok;
    wire req_take;
    wire req_wr_take;
    wire req_rd_take;
    wire flash_wr_take;

    svm_range_chk #(
        .W(ADDR_W)
    ) u_req_lo (
        .addr_in(req_addr_in),
        .first_in(RAM_LO_FIRST),
        .last_in(RAM_LO_LAST),
        .hit_out(req_in_ram_lo)
    );
    svm_range_chk #(
        .W(ADDR_W)
    ) u_req_hi (
        .addr_in(req_addr_in),
        .first_in(RAM_HI_FIRST),
        .last_in(RAM_HI_LAST),
        .hit_out(req_in_ram_hi)
    );
    svm_range_chk #(
        .W(ADDR_W)
    ) u_req_nv (
        .addr_in(req_addr_in),
        .first_in(NV_FIRST),
        .last_in(NV_LAST),
        .hit_out(req_in_nv)
    );
    assign req_mapped = req_in_ram_lo || req_in_ram_hi || req_in_nv;

    assign flash_src_ok = (req_src_in == SRC_MOVE)
                       || (req_src_in == SRC_TOOL);

    // stall anyone while sweeping or while the flash cell programs
    assign req_ready_out = (state_q == ST_IDLE);
    assign req_take = req_valid_in && req_ready_out;
    assign req_wr_take = req_take && req_write_in && req_mapped;
    assign req_rd_take = req_take && !req_write_in && req_mapped;
    assign flash_wr_take = req_wr_take && req_in_nv && flash_src_ok;

    // sweep address decode
    wire sw_in_ram_lo;
    wire sw_in_ram_hi;
    wire sw_in_nv;
    wire sw_in_ret;
    wire sw_retained;
    wire sw_clear;
    wire sw_copy;
    wire sweep_done;

    svm_range_chk #(
        .W(ADDR_W)
    ) u_sw_lo (
        .addr_in(sweep_addr_q),
        .first_in(RAM_LO_FIRST),
        .last_in(RAM_LO_LAST),
        .hit_out(sw_in_ram_lo)
    );
    svm_range_chk #(
        .W(ADDR_W)
    ) u_sw_hi (
        .addr_in(sweep_addr_q),
        .first_in(RAM_HI_FIRST),
        .last_in(RAM_HI_LAST),
        .hit_out(sw_in_ram_hi)
    );
    svm_range_chk #(
        .W(ADDR_W)
    ) u_sw_nv (
        .addr_in(sweep_addr_q),
        .first_in(NV_FIRST),
        .last_in(NV_LAST),
        .hit_out(sw_in_nv)
    );
    svm_range_chk #(
        .W(ADDR_W)
    ) u_sw_ret (
        .addr_in(sweep_addr_q),
        .first_in(ret_first_in),
        .last_in(ret_last_in),
        .hit_out(sw_in_ret)
    );
    assign sw_retained = ret_en_in && sw_in_ret;
    assign sw_clear = (state_q == ST_SWEEP)
                   && (sw_in_ram_lo || sw_in_ram_hi)
                   && !sw_retained;
    // flash overwrites ram only after power-up, not on a run entry
    assign sw_copy = (state_q == ST_SWEEP) && power_up_q && sw_in_nv;
    assign sweep_done = (sweep_addr_q == SWEEP_LAST);

    wire busy_last;
    assign busy_last = (busy_cnt_q == 8'h01);

    // program to run transition starts a clearing sweep
    wire run_entry;
    assign run_entry = run_mode_in && !run_q;

    // ram write port selection
    wire ram_we;
    wire [12:0] ram_waddr;
    wire [15:0] ram_wdata;
    wire [15:0] flash_rd_sweep;
    wire [15:0] ram_rd_req;

    assign flash_rd_sweep = flash_mem[sweep_addr_q[7:0]];
    assign ram_rd_req = ram_mem[req_addr_in];
    assign ram_we = sw_clear || sw_copy || req_wr_take;
    assign ram_waddr = (state_q == ST_SWEEP) ? sweep_addr_q : req_addr_in;
    assign ram_wdata = sw_copy ? flash_rd_sweep
                     : sw_clear ? CLEAR_VALUE
                     : req_wdata_in;

    always_comb begin
        state_d = state_q;
        sweep_addr_d = sweep_addr_q;
        power_up_d = power_up_q;
        busy_cnt_d = busy_cnt_q;
        case (state_q)
            ST_SWEEP: begin
                sweep_addr_d = sweep_addr_q + 13'h0001;
                if (sweep_done) begin
                    sweep_addr_d = '0;
                    power_up_d = 1'b0;
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (flash_wr_take) begin
                    busy_cnt_d = FLASH_WR_COUNT;
                    state_d = ST_FLASH_BUSY;
                end else if (run_entry) begin
                    sweep_addr_d = '0;
                    state_d = ST_SWEEP;
                end
            end
            ST_FLASH_BUSY: begin
                busy_cnt_d = busy_cnt_q - 8'h01;
                if (busy_last) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q <= ST_SWEEP;
            sweep_addr_q <= '0;
            power_up_q <= 1'b1;
            busy_cnt_q <= '0;
        end else begin
            state_q <= state_d;
            sweep_addr_q <= sweep_addr_d;
            power_up_q <= power_up_d;
            busy_cnt_q <= busy_cnt_d;
        end
    end

    // a run entry seen during busy is only tracked once idle again
    wire run_track;
    assign run_track = (state_q == ST_SWEEP)
                    || ((state_q == ST_IDLE) && !flash_wr_take);

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            run_q <= 1'b0;
        end else if (run_track) begin
            run_q <= run_mode_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (ram_we) begin
            ram_mem[ram_waddr] <= ram_wdata;
        end
    end

    always_ff @(posedge clk_in) begin
        if (flash_wr_take) begin
            flash_mem[req_addr_in[7:0]] <= req_wdata_in;
        end
    end

    // answer: one cycle after the take, reads come from ram only
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rsp_valid_q <= 1'b0;
            rsp_rdata_q <= '0;
            rsp_err_q <= 1'b0;
            rsp_flash_q <= 1'b0;
        end else begin
            rsp_valid_q <= req_take;
            rsp_err_q <= req_take && !req_mapped;
            rsp_flash_q <= flash_wr_take;
            if (req_rd_take) begin
                rsp_rdata_q <= ram_rd_req;
            end
        end
    end

    // program store: only the programming tool reaches it
    always_ff @(posedge clk_in) begin
        if (prog_wr_in) begin
            prog_mem[prog_addr_in] <= prog_wdata_in;
        end
    end

    // a read strobe alongside a write is dropped, the write wins
    wire prog_rd_take;
    assign prog_rd_take = prog_rd_in && !prog_wr_in;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prog_rvalid_q <= 1'b0;
            prog_rdata_q <= '0;
        end else begin
            prog_rvalid_q <= prog_rd_take;
            if (prog_rd_take) begin
                prog_rdata_q <= prog_mem[prog_addr_in];
            end
        end
    end

    assign rsp_valid_out = rsp_valid_q;
    assign rsp_rdata_out = rsp_rdata_q;
    assign rsp_err_out = rsp_err_q;
    assign rsp_flash_out = rsp_flash_q;
    assign flash_busy_out = (state_q == ST_FLASH_BUSY);
    assign sweep_busy_out = (state_q == ST_SWEEP);
    assign prog_rvalid_out = prog_rvalid_q;
    assign prog_rdata_out = prog_rdata_q;

endmodule

// *** dv/svm_checker.sv ***
module svm_checker
    import svm_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [1:0] req_src_in,
    input wire logic [12:0] req_addr_in,
    input wire logic req_ready_out,
    input wire logic rsp_valid_out,
    input wire logic rsp_err_out,
    input wire logic rsp_flash_out,
    input wire logic flash_busy_out,
    input wire logic sweep_busy_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] n_q;
    wire tk = req_valid_in && req_ready_out;
    wire lo = req_addr_in < RAM_LO_FIRST;
    wire nv = req_addr_in >= NV_FIRST && req_addr_in <= NV_LAST;
    wire fl = tk && req_write_in && nv && req_src_in inside {2'h1, 2'h2};
    // counts busy cycles so the program time can be checked at its fall
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) n_q <= 8'h00;
        else n_q <= flash_busy_out ? n_q + 8'h01 : 8'h00;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    property p_rsp; tk |=> rsp_valid_out; endproperty
    a_rsp: assert property (p_rsp) else $error("no answer");
    property p_idle; !tk |=> !rsp_valid_out; endproperty
    a_idle: assert property (p_idle) else $error("stray answer");
    property p_fl; fl |=> rsp_flash_out && flash_busy_out; endproperty
    a_fl: assert property (p_fl) else $error("no flash");
    property p_ram; tk && !fl |=> !rsp_flash_out && !flash_busy_out; endproperty
    a_ram: assert property (p_ram) else $error("bad flash");
    property p_len; $fell(flash_busy_out) |-> n_q == FLASH_WR_COUNT; endproperty
    a_len: assert property (p_len) else $error("busy length");
    property p_stall; flash_busy_out || sweep_busy_out |-> !req_ready_out; endproperty
    a_stall: assert property (p_stall) else $error("ready busy");
    property p_err; tk && lo |=> rsp_err_out; endproperty
    a_err: assert property (p_err) else $error("no error");
    property p_map; tk && !lo |=> !rsp_err_out; endproperty
    a_map: assert property (p_map) else $error("false error");
    c_fl: cover property (fl);
    c_err: cover property (tk && lo);
    c_sw: cover property ($fell(sweep_busy_out));
endmodule

bind svm_top svm_checker u_chk (.*);

// *** dv/svm_req_model.sv ***
module svm_req_model (
    input wire logic clk_in,
    input wire logic ready_in,
    output logic valid_out,
    output logic write_out,
    output logic [1:0] src_out,
    output logic [12:0] addr_out,
    output logic [15:0] wdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {valid_out, write_out, src_out, addr_out, wdata_out} = '0;
    // one request a call, so a flash value goes out once
    task automatic xfer(input logic w, input logic [1:0] s, input logic [12:0] a,
        input logic [15:0] d);
        int n = 0;
        repeat (1 + $urandom % 3) @(negedge clk_in);
        valid_out = 1'b1;
        {write_out, src_out, addr_out, wdata_out} = {w, s, a, d};
        while (ready_in !== 1'b1 && n < 300) begin
            @(negedge clk_in);
            n++;
        end
        if (n == 300) tb_top.summarize(1);
        @(negedge clk_in);
        valid_out = 1'b0;
        // released lines show the inverse, never the stale word
        {addr_out, wdata_out} = ~{a, d};
    endtask
endmodule

// *** dv/tb_top.sv ***
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
    $display("MISMATCH %0t %h %h", $time, (a), (b)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0, reset_n_in = 1'b0, run_mode_in = 1'b0;
    logic prog_wr_in = 1'b0, prog_rd_in = 1'b0, prog_rvalid_out;
    logic [9:0] prog_addr_in = 10'h000;
    logic [15:0] prog_wdata_in = 16'h0000, prog_rdata_out, req_wdata_in, rsp_rdata_out, dv;
    logic req_valid_in, req_write_in, req_ready_out, rsp_valid_out, rsp_err_out;
    logic rsp_flash_out, flash_busy_out, sweep_busy_out;
    logic [1:0] req_src_in;
    logic [12:0] req_addr_in, av;
    logic ret_en_in = 1'b1;
    logic [12:0] ret_first_in = 13'h1000, ret_last_in = 13'h10ff;
    int err_count = 0, cmp_count = 0;
    always #5 clk_in = ~clk_in;
    svm_top uut (.*);
    svm_req_model m (.clk_in(clk_in), .ready_in(req_ready_out), .valid_out(req_valid_in),
        .write_out(req_write_in), .src_out(req_src_in), .addr_out(req_addr_in),
        .wdata_out(req_wdata_in));
    task automatic summarize(input int e);
        err_count += e;
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic settle();
        int n = 0;
        repeat (2) @(negedge clk_in);
        reset_n_in = 1'b1;
        while (sweep_busy_out !== 1'b0 && n < 9000) begin
            @(negedge clk_in);
            n++;
        end
        if (n == 9000) summarize(1);
    endtask
    // read answer: valid only, with the word that the rules leave in ram
    function automatic logic [19:0] exp_rd(input logic keep, input logic [15:0] v);
        return {4'h8, keep ? v : 16'h0000};
    endfunction
    // write data is masked since the read word holds across writes
    task automatic op(input logic w, input logic [1:0] s, input logic [12:0] a,
        input logic [15:0] d, input logic [19:0] e);
        m.xfer(w, s, a, d);
        `CHK({rsp_valid_out, rsp_err_out, rsp_flash_out, flash_busy_out,
            w ? 16'h0000 : rsp_rdata_out}, e)
    endtask
    initial begin
        void'($urandom(22924));
        settle();
        for (int i = 0; i < 4; i++) begin
            av = 13'h1100 + 13'($urandom % 256);
            dv = 16'($urandom);
            op(1'b1, 2'h0, av, dv, 20'h80000);
            op(1'b1, 2'h3, av - 13'h0100, ~dv, 20'h80000);
            // first pass drops retention, so the kept word must clear too
            ret_en_in = (i != 0);
            run_mode_in = 1'b1;
            settle();
            op(1'b0, 2'h0, av, dv, exp_rd(1'b0, dv));
            op(1'b0, 2'h0, av - 13'h0100, dv, exp_rd(ret_en_in, ~dv));
            run_mode_in = 1'b0;
            ret_en_in = 1'b1;
        end
        op(1'b1, 2'h1, 13'h02ff, dv, 20'hc0000);
        op(1'b1, 2'h1, 13'h0f10, 16'ha5c3, 20'hb0000);
        op(1'b0, 2'h0, 13'h0f10, dv, exp_rd(1'b1, 16'ha5c3));
        op(1'b1, 2'h2, 13'h0fff, 16'h3c5a, 20'hb0000);
        op(1'b1, 2'h3, 13'h0f00, 16'h0f0f, 20'h80000);
        op(1'b1, 2'h0, 13'h0f10, 16'h1111, 20'h80000);
        op(1'b0, 2'h0, 13'h0f10, dv, exp_rd(1'b1, 16'h1111));
        reset_n_in = 1'b0;
        settle();
        op(1'b0, 2'h0, 13'h0f10, dv, exp_rd(1'b1, 16'ha5c3));
        op(1'b0, 2'h0, 13'h0fff, dv, exp_rd(1'b1, 16'h3c5a));
        op(1'b0, 2'h0, av - 13'h0100, dv, exp_rd(1'b1, ~dv));
        {prog_addr_in, prog_wdata_in, prog_wr_in} = {10'($urandom), 16'($urandom), 1'b1};
        @(negedge clk_in);
        {prog_wr_in, prog_rd_in} = 2'b01;
        @(negedge clk_in);
        prog_rd_in = 1'b0;
        `CHK({prog_rvalid_out, prog_rdata_out}, {1'b1, prog_wdata_in})
        summarize(0);
    end
endmodule
